/* File: hw/dcfa_pkg.sv */
// Shared constants and types for the dual channel fault alert block
package dcfa_pkg;

  localparam int unsigned CORE_CLK_PERIOD_PS = 5000;
  localparam int unsigned FAULT_TIME_US      = 100;
  localparam int unsigned FAULT_CYCLES       =
    (FAULT_TIME_US * 1000000) / CORE_CLK_PERIOD_PS;
  localparam int unsigned SOFTSTART_TIME_US  = 50;
  localparam int unsigned SOFTSTART_CYCLES   =
    (SOFTSTART_TIME_US * 1000000) / CORE_CLK_PERIOD_PS;
  localparam int unsigned TIMER_W            = 24;
  localparam int unsigned NUM_CH             = 2;
  localparam int unsigned FAULTS_PER_CH      = 4;

  localparam logic [6:0] ALERT_RESP_ADDR     = 7'h0C;

  localparam logic [7:0] REG_FAULT_FLAGS     = 8'h00;
  localparam logic [7:0] REG_REPORT_MASK     = 8'h01;
  localparam logic [7:0] REG_CONFIG          = 8'h02;

  localparam logic [7:0] FAULT_FLAGS_RESET   = 8'h00;
  localparam logic [7:0] REPORT_MASK_RESET   = 8'hFF;
  localparam logic [7:0] CONFIG_RESET        = 8'h00;
  localparam int unsigned LATCHOFF_BIT       = 7;

  localparam logic [3:0] BIT_COUNT_FULL      = 4'h8;
  localparam logic [1:0] BYTE_IDX_DATA       = 2'h2;

  // Bit order matches one channel nibble of the fault flag register
  typedef struct packed {
    logic overcurrent_fault;
    logic string_short_fault;
    logic string_open_fault;
    logic feedback_overvoltage_fault;
  } dcfa_chan_faults_type;

  typedef enum logic [4:0] {
    CH_OFF       = 5'h01,
    CH_SOFTSTART = 5'h02,
    CH_RUN       = 5'h04,
    CH_HICCUP    = 5'h08,
    CH_LATCHED   = 5'h10
  } dcfa_chan_state_type;

  typedef enum logic [4:0] {
    I2C_IDLE  = 5'h01,
    I2C_RX    = 5'h02,
    I2C_ACK   = 5'h04,
    I2C_TX    = 5'h08,
    I2C_TXACK = 5'h10
  } dcfa_i2c_state_type;

endpackage

/* File: hw/dcfa_fault_alert.sv */
// Fault supervision, alert reporting and I2C slave of the dual channel driver
// Behaviour
// - short flagged when feedback low after start-up
// - overcurrent sets flag and alert same cycle
// - short or overcurrent stops switching, gate high
// - hiccup or latch-off response, hiccup default
// - hiccup waits fault timer, then soft-start restart
// - after hiccup, alert held in I2C mode only
// - latch-off bit keeps channel stopped after fault
// - fault flags stay set until host clears
// - I2C mode alert only for flags with report enable set
// - channel 1 bits 0-3, channel 2 bits 4-7
// - report enables default to all ones
// - alert response inquiry answered with chip address
// - I2C mode alert held until response completes or reported flags are cleared
// - no further inquiry answers until new alert
// - no fresh alert for an uncleared flag
// - non-I2C alert driven directly by detectors
// - non-I2C short/overcurrent alert held through timer
// - overvoltage stops switching, gate high, flag, alert
// - open string sets flag and asserts alert
`timescale 1ns/1ps
`default_nettype none

module dcfa_fault_alert #(
  parameter int unsigned FAULT_CYCLES_P     = dcfa_pkg::FAULT_CYCLES,
  parameter int unsigned SOFTSTART_CYCLES_P = dcfa_pkg::SOFTSTART_CYCLES
) (
  input  wire logic                               i_core_clk,
  input  wire logic                               i_nrst,
  input  wire logic                               i_i2c_mode,
  input  wire logic                               i_enable_undervoltage_input,
  input  wire logic [6:0]                         i_chip_addr,
  input  wire dcfa_pkg::dcfa_chan_faults_type [1:0] i_faults,
  input  wire logic                               i_scl,
  input  wire logic                               i_sda,
  output logic [1:0]                              o_switch_en,
  output logic [1:0]                              o_disconnect_gate_drive,
  output logic                                    o_alert_oe_n,
  output logic                                    o_sda_oe_n
);
  import dcfa_pkg::*;

  localparam logic [TIMER_W-1:0] FAULT_LOAD =
    TIMER_W'(FAULT_CYCLES_P - 1);
  localparam logic [TIMER_W-1:0] SOFTSTART_LOAD =
    TIMER_W'(SOFTSTART_CYCLES_P - 1);

  // Register file
  logic [7:0] fault_flags;
  logic [7:0] fault_report_mask;
  logic [7:0] chip_config;
  logic       alert_pending;

  wire        latch_off = chip_config[LATCHOFF_BIT];

  // Channel-side results gathered from the generate loop
  wire [7:0]  fault_event;
  wire [1:0]  next_switch_en;
  wire [1:0]  hold_alert;
  wire [1:0]  direct_alert;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      dcfa_chan_state_type  state;
      dcfa_chan_state_type  next_state;
      logic [TIMER_W-1:0]   timer;
      logic [TIMER_W-1:0]   next_timer;
      dcfa_chan_faults_type flt;

      assign flt = i_faults[ch];

      wire short_seen = flt.string_short_fault & (state == CH_RUN);
      wire trip       = short_seen | flt.overcurrent_fault;
      wire fault_live = flt.string_short_fault | flt.overcurrent_fault;

      always_comb begin
        next_state = state;
        next_timer = (timer != '0) ? timer - 1'b1 : timer;
        if (!i_enable_undervoltage_input) begin
          next_state = CH_OFF;
          next_timer = '0;
        end else begin
          case (state)
            CH_OFF: begin
              next_state = CH_SOFTSTART;
              next_timer = SOFTSTART_LOAD;
            end
            CH_SOFTSTART, CH_RUN: begin
              if (trip && latch_off) begin
                next_state = CH_LATCHED;
              end else if (trip) begin
                next_state = CH_HICCUP;
                next_timer = FAULT_LOAD;
              end else if (state == CH_SOFTSTART && timer == '0) begin
                next_state = CH_RUN;
              end
            end
            CH_HICCUP: begin
              if (timer == '0 && !fault_live) begin
                next_state = CH_SOFTSTART;
                next_timer = SOFTSTART_LOAD;
              end
            end
            CH_LATCHED: next_state = CH_LATCHED;
            default: begin
              next_state = CH_OFF;
              next_timer = '0;
            end
          endcase
        end
      end

      always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          state <= CH_OFF;
          timer <= '0;
        end else begin
          state <= next_state;
          timer <= next_timer;
        end
      end

      assign next_switch_en[ch] =
        (next_state == CH_SOFTSTART || next_state == CH_RUN) &
        ~flt.feedback_overvoltage_fault;

      assign fault_event[ch*FAULTS_PER_CH +: FAULTS_PER_CH] =
        {flt.overcurrent_fault, short_seen, flt.string_open_fault,
         flt.feedback_overvoltage_fault};

      assign hold_alert[ch] =
        (next_state == CH_HICCUP) | (next_state == CH_LATCHED);
      assign direct_alert[ch] =
        flt.feedback_overvoltage_fault | flt.string_open_fault;
    end
  endgenerate

  // I2C slave
  dcfa_i2c_state_type i2c_state;
  dcfa_i2c_state_type next_i2c_state;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [1:0] byte_idx;
  logic [1:0] next_byte_idx;
  logic [7:0] pointer;
  logic [7:0] next_pointer;
  logic       is_read;
  logic       next_is_read;
  logic       is_ara;
  logic       next_is_ara;
  logic       next_sda_oe_n;
  logic       ara_done;
  logic       wr_stb;

  wire scl_rise  = i_scl & ~scl_q;
  wire scl_fall  = ~i_scl & scl_q;
  wire bus_start = scl_q & i_scl & sda_q & ~i_sda;
  wire bus_stop  = scl_q & i_scl & ~sda_q & i_sda;
  wire byte_done = scl_fall & (bit_cnt == BIT_COUNT_FULL);

  wire addr_hit  = (shift[7:1] == i_chip_addr);
  wire ara_hit   = (shift[7:1] == ALERT_RESP_ADDR) & shift[0] &
                   alert_pending;

  wire [7:0] reg_read_data =
    (pointer == REG_FAULT_FLAGS) ? fault_flags :
    (pointer == REG_REPORT_MASK) ? fault_report_mask :
    (pointer == REG_CONFIG)      ? chip_config : 8'h00;
  wire [7:0] tx_byte = is_ara ? {i_chip_addr, 1'b0} : reg_read_data;

  always_comb begin
    next_i2c_state = i2c_state;
    next_bit_cnt   = bit_cnt;
    next_shift     = shift;
    next_byte_idx  = byte_idx;
    next_pointer   = pointer;
    next_is_read   = is_read;
    next_is_ara    = is_ara;
    next_sda_oe_n  = o_sda_oe_n;
    ara_done       = 1'b0;
    wr_stb         = 1'b0;
    if (!i_i2c_mode || bus_stop) begin
      next_i2c_state = I2C_IDLE;
      next_sda_oe_n  = 1'b1;
    end else if (bus_start) begin
      next_i2c_state = I2C_RX;
      next_bit_cnt   = 4'h0;
      next_byte_idx  = 2'h0;
      next_is_ara    = 1'b0;
      next_sda_oe_n  = 1'b1;
    end else begin
      case (i2c_state)
        I2C_IDLE: next_sda_oe_n = 1'b1;
        I2C_RX: begin
          if (scl_rise) begin
            next_shift   = {shift[6:0], i_sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (byte_done) begin
            next_i2c_state = I2C_ACK;
            next_sda_oe_n  = 1'b0;
            if (byte_idx != BYTE_IDX_DATA) begin
              next_byte_idx = byte_idx + 2'h1;
            end
            if (byte_idx == 2'h0) begin
              next_is_read = shift[0];
              next_is_ara  = ara_hit & ~addr_hit;
              if (!(addr_hit || ara_hit)) begin
                next_i2c_state = I2C_IDLE;
                next_sda_oe_n  = 1'b1;
              end
            end else if (byte_idx == 2'h1) begin
              next_pointer = shift;
            end else begin
              wr_stb = 1'b1;
            end
          end
        end
        I2C_ACK: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (is_read) begin
              next_i2c_state = I2C_TX;
              next_shift     = tx_byte;
              next_sda_oe_n  = tx_byte[7];
            end else begin
              next_i2c_state = I2C_RX;
              next_sda_oe_n  = 1'b1;
            end
          end
        end
        I2C_TX: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (byte_done) begin
            next_i2c_state = I2C_TXACK;
            next_sda_oe_n  = 1'b1;
          end else if (scl_fall) begin
            next_shift    = {shift[6:0], 1'b0};
            next_sda_oe_n = shift[6];
          end
        end
        I2C_TXACK: begin
          if (scl_rise) begin
            ara_done = is_ara;
            if (i_sda) begin
              next_i2c_state = I2C_IDLE;
            end
          end else if (scl_fall) begin
            next_i2c_state = I2C_TX;
            next_bit_cnt   = 4'h0;
            next_shift     = tx_byte;
            next_sda_oe_n  = tx_byte[7];
          end
        end
        default: begin
          next_i2c_state = I2C_IDLE;
          next_sda_oe_n  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      i2c_state  <= I2C_IDLE;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      byte_idx   <= 2'h0;
      pointer    <= 8'h00;
      is_read    <= 1'b0;
      is_ara     <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else begin
      i2c_state  <= next_i2c_state;
      scl_q      <= i_scl;
      sda_q      <= i_sda;
      bit_cnt    <= next_bit_cnt;
      shift      <= next_shift;
      byte_idx   <= next_byte_idx;
      pointer    <= next_pointer;
      is_read    <= next_is_read;
      is_ara     <= next_is_ara;
      o_sda_oe_n <= next_sda_oe_n;
    end
  end

  // Register writes: flags are write-one-to-clear, new faults win
  wire wr_flags  = wr_stb & (pointer == REG_FAULT_FLAGS);
  wire wr_mask   = wr_stb & (pointer == REG_REPORT_MASK);
  wire wr_config = wr_stb & (pointer == REG_CONFIG);

  wire [7:0] next_fault_flags =
    (fault_flags & ~(wr_flags ? shift : 8'h00)) | fault_event;
  wire [7:0] next_report_mask = wr_mask ? shift : fault_report_mask;
  wire [7:0] next_config      = wr_config ? shift : chip_config;

  wire new_report = |(fault_event & ~fault_flags & fault_report_mask);
  wire nothing_left = ~|(fault_flags & fault_report_mask);

  wire next_alert_pending = i_i2c_mode &
    (new_report | (alert_pending & ~ara_done & ~nothing_left));

  wire next_alert_oe_n = i_i2c_mode ? ~next_alert_pending :
    ~(|direct_alert | |hold_alert);

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fault_flags       <= FAULT_FLAGS_RESET;
      fault_report_mask <= REPORT_MASK_RESET;
      chip_config       <= CONFIG_RESET;
      alert_pending     <= 1'b0;
    end else begin
      fault_flags       <= next_fault_flags;
      fault_report_mask <= next_report_mask;
      chip_config       <= next_config;
      alert_pending     <= next_alert_pending;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_switch_en             <= 2'h0;
      o_disconnect_gate_drive <= 2'h3;
      o_alert_oe_n            <= 1'b1;
    end else begin
      o_switch_en             <= next_switch_en;
      o_disconnect_gate_drive <= ~next_switch_en;
      o_alert_oe_n            <= next_alert_oe_n;
    end
  end

endmodule

`default_nettype wire

/* File: testbench/dcfa_fault_alert_asserts.sv */
// Port-level checker for the dual channel fault alert block
`timescale 1ns/1ps
`default_nettype none
module dcfa_fault_alert_asserts #(
  parameter int unsigned FAULT_CYCLES_P     = 20,
  parameter int unsigned SOFTSTART_CYCLES_P = 10
) (
  input wire logic                                 i_core_clk,
  input wire logic                                 i_nrst,
  input wire logic                                 i_i2c_mode,
  input wire logic                                 i_enable_undervoltage_input,
  input wire logic [6:0]                           i_chip_addr,
  input wire dcfa_pkg::dcfa_chan_faults_type [1:0] i_faults,
  input wire logic                                 i_scl,
  input wire logic                                 i_sda,
  input wire logic [1:0]                           o_switch_en,
  input wire logic [1:0]                           o_disconnect_gate_drive,
  input wire logic                                 o_alert_oe_n,
  input wire logic                                 o_sda_oe_n
);
  import dcfa_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  gate_mirror_a: assert property (
    o_disconnect_gate_drive == ~o_switch_en) else $error("gate not inverse");
  oc_stop_a: assert property (
    i_faults[0].overcurrent_fault |=> !o_switch_en[0])
    else $error("overcurrent did not stop switching");
  ov_stop_a: assert property (
    i_faults[1].feedback_overvoltage_fault |=> !o_switch_en[1])
    else $error("overvoltage did not stop switching");
  hiccup_wait_a: assert property (
    i_faults[0].overcurrent_fault && o_switch_en[0] |=> !o_switch_en[0] [*8])
    else $error("restart before fault timer");
  direct_alert_a: assert property (
    !i_i2c_mode && (i_faults[0].string_open_fault ||
    i_faults[1].feedback_overvoltage_fault) |=> !o_alert_oe_n)
    else $error("direct alert missing");
  direct_hold_a: assert property (
    !i_i2c_mode && i_faults[1].overcurrent_fault |=> !o_alert_oe_n [*8])
    else $error("direct alert not held");
  alert_release_a: assert property (
    i_i2c_mode && $past(i_i2c_mode) && $rose(o_alert_oe_n)
    |-> $past(i_scl) != $past(i_scl, 2))
    else $error("alert released away from an SCL edge");
  alert_cause_a: assert property (
    i_i2c_mode && $past(i_i2c_mode) && $fell(o_alert_oe_n)
    |-> $past(i_faults) != 8'h00) else $error("alert without fault");

  oc_trip_c: cover property (i_faults[0].overcurrent_fault && o_switch_en[0]);
  release_c: cover property (i_i2c_mode && $rose(o_alert_oe_n));
  direct_c: cover property (!i_i2c_mode && !o_alert_oe_n);
endmodule
`default_nettype wire

/* File: testbench/dcfa_i2c_host.sv */
// I2C host model issuing register and alert response transfers
`timescale 1ns/1ps
`default_nettype none
module dcfa_i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output var logic  o_scl,
  output var logic  o_sda_oe_n
);
  import dcfa_pkg::*;
  initial begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic send_bit(input logic b, output logic r);
    o_sda_oe_n <= b;
    wait_clk(3);
    o_scl <= 1'b1;
    wait_clk(4);
    r = i_sda;
    o_scl <= 1'b0;
    wait_clk(3);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) send_bit(d[i], q[i]);
    send_bit(ack_in, ack);
  endtask
  // Release SDA while SCL is low, raise SCL, then pull SDA low
  task automatic start;
    o_sda_oe_n <= 1'b1;
    wait_clk(3);
    o_scl <= 1'b1;
    wait_clk(4);
    o_sda_oe_n <= 1'b0;
    wait_clk(4);
    o_scl <= 1'b0;
    wait_clk(3);
  endtask
  task automatic stop;
    o_sda_oe_n <= 1'b0;
    wait_clk(3);
    o_scl <= 1'b1;
    wait_clk(4);
    o_sda_oe_n <= 1'b1;
    wait_clk(4);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, a);
    xfer(ptr, 1'b1, q, a);
    xfer(d, 1'b1, q, a);
    stop();
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] q);
    logic a;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, a);
    xfer(ptr, 1'b1, q, a);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, q, a);
    xfer(8'hFF, 1'b1, q, a);
    stop();
  endtask
  task automatic ara(output logic [7:0] q, output logic a);
    logic n;
    start();
    xfer({ALERT_RESP_ADDR, 1'b1}, 1'b1, q, a);
    xfer(8'hFF, 1'b1, q, n);
    stop();
  endtask
endmodule
`default_nettype wire

/* File: testbench/dcfa_fault_alert_tb.sv */
// Self-checking bench for the dual channel fault alert block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin \
  error_cnt++; $display("mismatch %s exp %0h got %0h", nm, e, a); end end
module dcfa_fault_alert_tb;
  import dcfa_pkg::*;
  localparam int         FC   = 20;
  localparam int         SC   = 10;
  localparam logic [6:0] ADDR = 7'h2A;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       mode = 1'b1;
  logic       en = 1'b1;
  logic [7:0] faults = 8'h00;
  logic       scl;
  logic       host_oe_n;
  logic       sda_oe_n;
  logic       alert_oe_n;
  logic [1:0] sw_en;
  logic [1:0] gate;
  wire        sda = host_oe_n & sda_oe_n;
  int         error_cnt = 0;
  int         comparisons = 0;
  logic [7:0] q;
  logic       ack;
  always #2.5 clk = ~clk;
  dcfa_fault_alert #(.FAULT_CYCLES_P(FC), .SOFTSTART_CYCLES_P(SC)) u_dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_i2c_mode(mode),
    .i_enable_undervoltage_input(en), .i_chip_addr(ADDR), .i_faults(faults),
    .i_scl(scl), .i_sda(sda), .o_switch_en(sw_en),
    .o_disconnect_gate_drive(gate), .o_alert_oe_n(alert_oe_n),
    .o_sda_oe_n(sda_oe_n));
  dcfa_i2c_host #(.DEV_ADDR(ADDR)) u_host (.i_core_clk(clk), .i_sda(sda),
    .o_scl(scl), .o_sda_oe_n(host_oe_n));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic close_out;
    $display("counts: %0d compared, %0d mismatched", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    cyc(60000);
    error_cnt++;
    close_out();
  end
  initial begin
    cyc(2);
    nrst <= 1'b1;
    cyc(SC + 4);
    u_host.rd(REG_REPORT_MASK, q);
    `CHK("mask", 8'hFF, q)
    u_host.rd(8'h05, q);
    `CHK("unmapped", 8'h00, q)
    `CHK("alert", 1'b1, alert_oe_n)
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      faults <= 8'h01 << i;
      cyc(3);
      faults <= 8'h00;
      cyc(FC + SC + 4);
      `CHK("alert", 1'b0, alert_oe_n)
      u_host.rd(REG_FAULT_FLAGS, q);
      `CHK("flag", 8'h01 << i, q)
      u_host.ara(q, ack);
      `CHK("ara", {ADDR, 1'b0}, q)
      `CHK("release", 1'b1, alert_oe_n)
      u_host.wr(REG_FAULT_FLAGS, 8'hFF);
    end
    $display("test fault map done");
    faults <= 8'h08;
    cyc(1);
    #1 `CHK("switch", 1'b0, sw_en[0])
    `CHK("gate", 1'b1, gate[0])
    `CHK("alert", 1'b0, alert_oe_n)
    @(posedge clk) faults <= 8'h00;
    cyc(FC - 4);
    #1 `CHK("held", 1'b0, sw_en[0])
    cyc(6);
    #1 `CHK("restart", 1'b1, sw_en[0])
    u_host.ara(q, ack);
    `CHK("ara ack", 1'b0, ack)
    u_host.ara(q, ack);
    `CHK("ara again", 1'b1, ack)
    faults <= 8'h08;
    cyc(3);
    faults <= 8'h00;
    #1 `CHK("repeat", 1'b1, alert_oe_n)
    cyc(FC + SC);
    u_host.rd(REG_FAULT_FLAGS, q);
    `CHK("sticky", 8'h08, q)
    u_host.wr(REG_FAULT_FLAGS, 8'h08);
    u_host.rd(REG_FAULT_FLAGS, q);
    `CHK("cleared", 8'h00, q)
    $display("test hiccup done");
    u_host.wr(REG_REPORT_MASK, 8'hEF);
    faults <= 8'h10;
    cyc(1);
    #1 `CHK("ov stop", 1'b0, sw_en[1])
    @(posedge clk) faults <= 8'h00;
    cyc(3);
    `CHK("masked", 1'b1, alert_oe_n)
    u_host.rd(REG_FAULT_FLAGS, q);
    `CHK("ov flag", 8'h10, q)
    u_host.wr(REG_FAULT_FLAGS, 8'hFF);
    u_host.wr(REG_REPORT_MASK, 8'hFF);
    $display("test mask done");
    u_host.wr(REG_CONFIG, 8'h80);
    faults <= 8'h80;
    cyc(3);
    faults <= 8'h00;
    cyc(FC + SC + 10);
    #1 `CHK("latched", 1'b0, sw_en[1])
    @(posedge clk) en <= 1'b0;
    cyc(2);
    en <= 1'b1;
    cyc(3);
    #1 `CHK("unlatched", 1'b1, sw_en[1])
    @(posedge clk) faults <= 8'h40;
    @(posedge clk) faults <= 8'h00;
    #1 `CHK("ss mask", 1'b1, sw_en[1])
    u_host.ara(q, ack);
    u_host.wr(REG_FAULT_FLAGS, 8'hFF);
    u_host.wr(REG_CONFIG, 8'h00);
    $display("test latch done");
    mode <= 1'b0;
    faults <= 8'h02;
    cyc(2);
    #1 `CHK("direct", 1'b0, alert_oe_n)
    @(posedge clk) faults <= 8'h00;
    cyc(2);
    #1 `CHK("direct off", 1'b1, alert_oe_n)
    @(posedge clk) faults <= 8'h80;
    @(posedge clk) faults <= 8'h00;
    cyc(FC - 4);
    #1 `CHK("direct hold", 1'b0, alert_oe_n)
    cyc(8);
    #1 `CHK("direct end", 1'b1, alert_oe_n)
    @(posedge clk) mode <= 1'b1;
    $display("test direct done");
    close_out();
  end
endmodule
bind dcfa_fault_alert dcfa_fault_alert_asserts #(
  .FAULT_CYCLES_P(FAULT_CYCLES_P), .SOFTSTART_CYCLES_P(SOFTSTART_CYCLES_P))
  u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_i2c_mode(i_i2c_mode),
  .i_enable_undervoltage_input(i_enable_undervoltage_input),
  .i_chip_addr(i_chip_addr), .i_faults(i_faults), .i_scl(i_scl),
  .i_sda(i_sda), .o_switch_en(o_switch_en),
  .o_disconnect_gate_drive(o_disconnect_gate_drive),
  .o_alert_oe_n(o_alert_oe_n), .o_sda_oe_n(o_sda_oe_n));
`default_nettype wire
